// file: sim/eos_field_model.sv
// far side model: override contact, stop and enable, keypad, output lamp
`timescale 1ns/100ps

module eos_field_model
(
    // clock
    input  wire clk_in,
    // digital output from the drive
    input  wire dout_in,
    // contacts, keypad and lamp
    output reg  fire_n_out,
    output reg  key_out,
    output reg  stop_out,
    output reg  enable_out,
    output reg  lamp_out
);
    // contact closed, drive enabled at start
    initial
    begin
        fire_n_out = 1'b1;
        key_out = 1'b0;
        stop_out = 1'b0;
        enable_out = 1'b1;
    end
    always @(posedge clk_in)
        lamp_out <= dout_in;
    task set_contact(input open);
        @(posedge clk_in);
        fire_n_out <= ~open;
    endtask
    task press_key;
        @(posedge clk_in);
        key_out <= 1'b1;
        @(posedge clk_in);
        key_out <= 1'b0;
    endtask
    task set_stop(input on);
        @(posedge clk_in);
        stop_out <= on;
        enable_out <= ~on;
    endtask
endmodule

// file: sim/eos_supervisor_props.sv
// concurrent checks on the override supervisor ports
`timescale 1ns/100ps

module eos_supervisor_props
(
    // clock and reset
    input wire       CORE_CLK_IN,
    input wire       RESET_IN,
    // watched inputs
    input wire       FIRE_INPUT_N_IN,
    input wire       OVERVOLTAGE_FAULT_IN,
    input wire       OVERCURRENT_FAULT_IN,
    // watched outputs
    input wire       HREADYOUT_OUT,
    input wire       HRESP_OUT,
    input wire       FIRE_MODE_ALARM_OUT,
    input wire [3:0] OPERATING_STATE_OUT,
    input wire       DIGITAL_OUTPUT_OUT,
    input wire       PULSE_ENABLE_OUT,
    input wire       FAULT_TRIP_OUT,
    input wire       FAULT_RESET_OUT,
    input wire       IRQ_OUT
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (RESET_IN);
    // override shown on the state indicator
    wire ovr = (OPERATING_STATE_OUT == 4'h3);
    // bus never stalls and never errors
    AST_BUS_OKAY: assert property (HREADYOUT_OUT && !HRESP_OUT)
        else $error("bus slave stalled or errored");
    AST_ALARM_ENTRY: assert property ($rose(FIRE_MODE_ALARM_OUT) |-> ovr)
        else $error("alarm rose outside override");
    AST_DOUT_OVR: assert property (DIGITAL_OUTPUT_OUT |-> ovr)
        else $error("digital output high outside override");
    // indicator held while input stays low
    AST_STATE_HOLD: assert property (ovr && !FIRE_INPUT_N_IN && $past(!FIRE_INPUT_N_IN)
        |=> ovr) else $error("override indicator dropped while active");
    // input back high leaves override in two edges
    AST_EXIT: assert property ($rose(FIRE_INPUT_N_IN) ##1 FIRE_INPUT_N_IN
        |=> !ovr) else $error("override not left after input released");
    // pulses kept despite stop while fault free
    AST_NO_STOP: assert property (ovr && PULSE_ENABLE_OUT && !FIRE_INPUT_N_IN
        && $past(!FIRE_INPUT_N_IN) && !FAULT_TRIP_OUT && !OVERCURRENT_FAULT_IN
        && !OVERVOLTAGE_FAULT_IN && !$past(OVERCURRENT_FAULT_IN)
        && !$past(OVERVOLTAGE_FAULT_IN) |=> PULSE_ENABLE_OUT)
        else $error("pulses dropped in override");
    // automatic reset is a single pulse
    AST_ARST_PULSE: assert property (FAULT_RESET_OUT |=> !FAULT_RESET_OUT)
        else $error("fault reset pulse too long");
    AST_RST_QUIET: assert property ($fell(RESET_IN) |-> !IRQ_OUT && !ovr
        && !FIRE_MODE_ALARM_OUT && !FAULT_TRIP_OUT) else $error("outputs not reset");
    // main scenarios reached
    COV_OVR: cover property ($rose(ovr));
    COV_ARST: cover property (FAULT_RESET_OUT);
    COV_IRQ: cover property (IRQ_OUT);
endmodule

bind eos_supervisor eos_supervisor_props chk_u (.CORE_CLK_IN, .RESET_IN,
    .FIRE_INPUT_N_IN, .OVERVOLTAGE_FAULT_IN, .OVERCURRENT_FAULT_IN, .HREADYOUT_OUT,
    .HRESP_OUT, .FIRE_MODE_ALARM_OUT, .OPERATING_STATE_OUT, .DIGITAL_OUTPUT_OUT,
    .PULSE_ENABLE_OUT, .FAULT_TRIP_OUT, .FAULT_RESET_OUT, .IRQ_OUT);

// file: sim/eos_supervisor_tb_top.sv
// self-checking bench of the override supervisor
`timescale 1ns/100ps
`include "eos_regs.vh"

module eos_supervisor_tb_top;
    reg         clk, rst, hsel, hwrite, oc, ov, other;
    reg  [1:0]  htrans;
    reg  [7:0]  haddr;
    reg  [31:0] hwdata, rd;
    wire [31:0] hrdata;
    wire        hready, hresp, fire_n, key, stop, enable, lamp;
    wire        alarm, dout, pulse, trip, frst, irq;
    wire [3:0]  state;
    wire [15:0] spd;
    reg  [15:0] spdin;
    integer     mismatches, n_compared, i, n;

    // ----------------------------------------------------------------
    // design, far side and clock
    // ----------------------------------------------------------------
    // short tick so one second is 10000 cycles
    eos_supervisor #(.TICK_CYC(10)) dut_u (.CORE_CLK_IN(clk), .RESET_IN(rst),
        .HSEL_IN(hsel), .HADDR_IN({24'h00_0000, haddr}), .HTRANS_IN(htrans),
        .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready),
        .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
        .FIRE_INPUT_N_IN(fire_n), .KEY_PRESS_IN(key), .STOP_CMD_IN(stop),
        .GENERAL_ENABLE_IN(enable), .OVERVOLTAGE_FAULT_IN(ov),
        .OVERCURRENT_FAULT_IN(oc), .OTHER_FAULT_IN(other), .SPEED_REF_IN(spdin),
        .FIRE_MODE_ALARM_OUT(alarm), .OPERATING_STATE_OUT(state),
        .DIGITAL_OUTPUT_OUT(dout), .PULSE_ENABLE_OUT(pulse), .SPEED_REF_OUT(spd),
        .FAULT_TRIP_OUT(trip), .FAULT_RESET_OUT(frst), .IRQ_OUT(irq));
    eos_field_model field_u (.clk_in(clk), .dout_in(dout), .fire_n_out(fire_n),
        .key_out(key), .stop_out(stop), .enable_out(enable), .lamp_out(lamp));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task close_out;
    begin
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    task chk(input [95:0] nm, input [31:0] got, input [31:0] exp);
    begin
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("wrong value %0s exp %h got %h", nm, exp, got);
        end
    end
    endtask
    // look 1 ns after the edge, outputs settled
    task waitc(input integer c);
    begin
        repeat (c) @(posedge clk);
        #1;
    end
    endtask
    // one single ahb transfer, waits on ready in both phases
    task bus(input w, input [7:0] a, input [31:0] d);
    begin
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= a;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    end
    endtask
    // fault pulse, then count edges to the auto reset
    task fault_wait(input v);
    begin
        @(posedge clk);
        {ov, oc} <= {v, !v};
        @(posedge clk);
        {ov, oc} <= 2'b00;
        n = 0;
        while (frst !== 1'b1 && n < 10100)
        begin
            waitc(1);
            n = n + 1;
        end
    end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_regs;
    begin
        bus(0, `EOS_CTRL_OFS, 0);
        chk("ctrl", rd, 0);
        bus(0, `EOS_MAX_SPEED_OFS, 0);
        chk("maxspd", rd, 32'h0000_7FFF);
        bus(0, 8'h18, 0);
        chk("unmapped", rd, 0);
        bus(1, `EOS_MAX_SPEED_OFS, 32'h0000_1234);
        bus(0, `EOS_MAX_SPEED_OFS, 0);
        chk("maxspd", rd, 32'h0000_1234);
    end
    endtask
    // configurations off and reserved ignore the input
    task t_off;
    begin
        for (i = 0; i < 4; i = i + 3)
        begin
            bus(1, `EOS_CTRL_OFS, i | 32'h0000_0100);
            field_u.set_contact(1);
            waitc(4);
            chk("alarm", alarm, 0);
            chk("dout", dout, 0);
            field_u.set_contact(0);
        end
    end
    endtask
    // every active configuration: entry, stop, key, exit
    task t_cfg;
    begin
        for (i = 1; i < 5; i = i * 2)
        begin
            bus(1, `EOS_CTRL_OFS, i | 32'h0000_0100);
            field_u.set_contact(1);
            waitc(4);
            chk("alarm", alarm, 1);
            chk("state", state, `EOS_OPST_FIRE);
            chk("lamp", lamp, 1);
            if (i != 4)
                chk("speed", spd, (i == 2) ? 16'h1234 : 16'h0100);
            chk("pulse", pulse, i != 4);
            field_u.set_stop(1);
            waitc(4);
            chk("pulse", pulse, i != 4);
            field_u.press_key;
            waitc(3);
            chk("alarm", alarm, 0);
            chk("state", state, `EOS_OPST_FIRE);
            field_u.set_stop(0);
            field_u.set_contact(0);
            waitc(4);
            chk("dout", dout, 0);
        end
        bus(0, `EOS_ENTRY_LOG_OFS, 0);
        chk("log", rd, 3);
        bus(0, `EOS_STATUS_OFS, 0);
        chk("seen", rd[`EOS_STAT_SEEN_BIT], 1);
    end
    endtask
    // entry interrupt masked, unmasked, then cleared
    task t_irq;
    begin
        bus(1, `EOS_IRQ_STATUS_OFS, 32'h0000_001F);
        bus(1, `EOS_CTRL_OFS, 32'h0000_0001);
        field_u.set_contact(1);
        waitc(4);
        chk("irq", irq, 0);
        bus(1, `EOS_IRQ_MASK_OFS, 32'h0000_0001);
        waitc(2);
        chk("irq", irq, 1);
        bus(1, `EOS_IRQ_STATUS_OFS, 32'h0000_0001);
        waitc(2);
        chk("irq", irq, 0);
        field_u.set_contact(0);
        bus(1, `EOS_IRQ_MASK_OFS, 0);
    end
    endtask
    // auto reset unlimited, then zero tries
    task t_arst;
    begin
        bus(1, `EOS_CTRL_OFS, 32'h0000_0009);
        field_u.set_contact(1);
        waitc(4);
        @(posedge clk);
        other <= 1'b1;
        waitc(3);
        chk("trip", trip, 0);
        other <= 1'b0;
        fault_wait(0);
        chk("delay", (n > 9990) && (n < 10015), 1);
        waitc(3);
        chk("trip", trip, 0);
        bus(1, `EOS_CTRL_OFS, 32'h0000_0001);
        fault_wait(1);
        chk("noreset", n, 10100);
        chk("trip", trip, 1);
        field_u.set_contact(0);
        bus(1, `EOS_CTRL_OFS, 32'h0000_0201);
        waitc(1);
        chk("trip", trip, 0);
        other <= 1'b1;
        waitc(3);
        chk("trip", trip, 1);
        other <= 1'b0;
    end
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        mismatches = 0;
        n_compared = 0;
        rst = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        haddr = 8'h00;
        hwdata = 32'h0000_0000;
        {oc, ov} = 2'b00;
        spdin = 16'h0100;
        other = 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_off;
        t_cfg;
        t_irq;
        t_arst;
        close_out;
    end
    // about twice the expected run length
    initial
    begin
        #400000;
        mismatches = mismatches + 1;
        close_out;
    end
endmodule

// file: verilog/eos_delay.v
// delay timer counting enable ticks while armed, one done pulse at the end
`timescale 1ns/100ps

module eos_delay
#(
    parameter DELAY_TICKS = 1000
)
(
    // clock and reset
    input  wire        clk_in,
    input  wire        reset_in,
    // control
    input  wire        arm_in,
    input  wire        tick_in,
    // status
    output wire        idle_out,
    output reg         done_out
);

    localparam ST_IDLE = 1'b0;
    localparam ST_WAIT = 1'b1;

    reg        state;
    reg [15:0] ticks;

    assign idle_out = (state == ST_IDLE);

    // dropping the arm abandons the wait without a pulse
    always @(posedge clk_in)
    begin
        if (reset_in)
        begin
            state    <= ST_IDLE;
            ticks    <= 16'h0000;
            done_out <= 1'b0;
        end
        else
        begin
            done_out <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    ticks <= 16'h0000;
                    if (arm_in)
                        state <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (!arm_in)
                        state <= ST_IDLE;
                    else if (tick_in && ticks == DELAY_TICKS - 1)
                    begin
                        done_out <= 1'b1;
                        state    <= ST_IDLE;
                    end
                    else if (tick_in)
                        ticks <= ticks + 16'h0001;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

endmodule

// file: verilog/eos_regs.vh
// register map, field layout, reset values and timing of the override supervisor
`ifndef EOS_REGS_VH
`define EOS_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define EOS_CTRL_OFS        8'h00
`define EOS_STATUS_OFS      8'h04
`define EOS_IRQ_STATUS_OFS  8'h08
`define EOS_IRQ_MASK_OFS    8'h0C
`define EOS_ENTRY_LOG_OFS   8'h10
`define EOS_MAX_SPEED_OFS   8'h14

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define EOS_CTRL_CFG_LSB    0
`define EOS_CTRL_CFG_MSB    2
`define EOS_CTRL_POLICY_BIT 3
`define EOS_CTRL_GAR_LSB    4
`define EOS_CTRL_GAR_MSB    7
`define EOS_CTRL_DOUT_BIT   8
`define EOS_CTRL_FCLR_BIT   9
`define EOS_CTRL_WIDTH      9

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define EOS_STAT_ACTIVE_BIT 0
`define EOS_STAT_INPUT_BIT  1
`define EOS_STAT_SEEN_BIT   2
`define EOS_STAT_TRIP_BIT   3
`define EOS_STAT_ALARM_BIT  4
`define EOS_STAT_OPST_LSB   8
`define EOS_STAT_OPST_MSB   11
`define EOS_STAT_TRIES_LSB  12
`define EOS_STAT_TRIES_MSB  15

// ----------------------------------------------------------------
// interrupt status and mask bits
// ----------------------------------------------------------------
`define EOS_IRQ_ENTER_BIT   0
`define EOS_IRQ_EXIT_BIT    1
`define EOS_IRQ_CRIT_BIT    2
`define EOS_IRQ_SUPP_BIT    3
`define EOS_IRQ_ARST_BIT    4
`define EOS_IRQ_WIDTH       5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define EOS_CTRL_RST        9'h000
`define EOS_IRQ_MASK_RST    5'h00
`define EOS_MAX_SPEED_RST   16'h7FFF

// ----------------------------------------------------------------
// override configuration codes and operating state codes
// ----------------------------------------------------------------
`define EOS_CFG_OFF         3'h0
`define EOS_CFG_ALARM       3'h1
`define EOS_CFG_MAXSPD      3'h2
`define EOS_CFG_RSVD        3'h3
`define EOS_CFG_COAST       3'h4
`define EOS_OPST_READY      4'h0
`define EOS_OPST_RUN        4'h1
`define EOS_OPST_FAULT      4'h2
`define EOS_OPST_FIRE       4'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define EOS_CLK_MHZ         100
`define EOS_TICK_US         1000
`define EOS_TICK_CYC        (`EOS_TICK_US * `EOS_CLK_MHZ)
`define EOS_ARST_DELAY_S    1
`define EOS_ARST_DELAY_MS   (`EOS_ARST_DELAY_S * 1000)

`endif

// file: verilog/eos_supervisor.v
// emergency override supervisor with ahb-lite register slave
`timescale 1ns/100ps
`include "eos_regs.vh"

module eos_supervisor
#(
    parameter TICK_CYC = `EOS_TICK_CYC
)
(
    // clock and reset
    input  wire        CORE_CLK_IN,
    input  wire        RESET_IN,
    // ahb-lite slave
    input  wire        HSEL_IN,
    input  wire [31:0] HADDR_IN,
    input  wire [1:0]  HTRANS_IN,
    input  wire        HWRITE_IN,
    input  wire [2:0]  HSIZE_IN,
    input  wire [31:0] HWDATA_IN,
    input  wire        HREADY_IN,
    output reg  [31:0] HRDATA_OUT,
    output reg         HREADYOUT_OUT,
    output reg         HRESP_OUT,
    // drive side inputs
    input  wire        FIRE_INPUT_N_IN,
    input  wire        KEY_PRESS_IN,
    input  wire        STOP_CMD_IN,
    input  wire        GENERAL_ENABLE_IN,
    input  wire        OVERVOLTAGE_FAULT_IN,
    input  wire        OVERCURRENT_FAULT_IN,
    input  wire        OTHER_FAULT_IN,
    input  wire [15:0] SPEED_REF_IN,
    // drive side outputs
    output reg         FIRE_MODE_ALARM_OUT,
    output reg  [3:0]  OPERATING_STATE_OUT,
    output reg         DIGITAL_OUTPUT_OUT,
    output reg         PULSE_ENABLE_OUT,
    output reg  [15:0] SPEED_REF_OUT,
    output reg         FAULT_TRIP_OUT,
    output reg         FAULT_RESET_OUT,
    output reg         IRQ_OUT
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    reg  [8:0]  ctrl;
    reg  [4:0]  irq_status;
    reg  [4:0]  irq_mask;
    reg  [15:0] max_speed;
    reg  [15:0] entry_count;
    reg         seen;
    reg         active;
    reg         alarm;
    reg         trip_crit;
    reg         trip_other;
    reg  [3:0]  tries;
    reg         wr_pend;
    reg  [7:0]  wr_addr;
    reg  [4:0]  next_irq_status;
    reg  [31:0] rd_mux;
    reg  [3:0]  next_opst;

    wire        addr_phase;
    wire [7:0]  addr_ofs;
    wire [2:0]  cfg;
    wire        cfg_valid;
    wire        next_active;
    wire        entering;
    wire        leaving;
    wire        clr_pulse;
    wire        crit_now;
    wire        other_now;
    wire        tries_left;
    wire        arst_allowed;
    wire        arst_done;
    wire        timer_idle;
    wire        tick;
    wire [4:0]  events;
    wire [4:0]  w1c;
    wire        run_normal;

    assign cfg = ctrl[`EOS_CTRL_CFG_MSB:`EOS_CTRL_CFG_LSB];

    // ----------------------------------------------------------------
    // override mode qualification
    // ----------------------------------------------------------------
    // config zero disables input
    assign cfg_valid = (cfg == `EOS_CFG_ALARM) || (cfg == `EOS_CFG_MAXSPD) ||
                       (cfg == `EOS_CFG_COAST);
    assign next_active = cfg_valid && !FIRE_INPUT_N_IN;
    assign entering    = next_active && !active;
    assign leaving     = !next_active && active;

    // mode flag and alarm; a key press in the entry cycle loses to the entry
    always @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN)
        begin
            active <= 1'b0;
            alarm  <= 1'b0;
        end
        else
        begin
            active <= next_active;
            if (entering)
                alarm <= 1'b1;
            else if (KEY_PRESS_IN || leaving)
                alarm <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // event record
    // ----------------------------------------------------------------
    // sticky record of override use; only a reset wipes it
    always @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN)
        begin
            seen        <= 1'b0;
            entry_count <= 16'h0000;
        end
        else if (entering)
        begin
            seen <= 1'b1;
            if (entry_count != 16'hFFFF)
                entry_count <= entry_count + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // fault handling
    // ----------------------------------------------------------------
    // critical faults stay live
    assign crit_now   = OVERVOLTAGE_FAULT_IN || OVERCURRENT_FAULT_IN;
    assign other_now  = OTHER_FAULT_IN && !active;
    assign clr_pulse  = wr_pend && (wr_addr == `EOS_CTRL_OFS) &&
                        HWDATA_IN[`EOS_CTRL_FCLR_BIT];
    assign tries_left = (tries < ctrl[`EOS_CTRL_GAR_MSB:`EOS_CTRL_GAR_LSB]);
    assign arst_allowed = active && trip_crit &&
                          (ctrl[`EOS_CTRL_POLICY_BIT] || tries_left);

    // one second wait, restarted whenever the timer sits idle
    eos_tick #(
        .TICK_CYC (TICK_CYC)
    ) u_tick (
        .clk_in   (CORE_CLK_IN),
        .reset_in (RESET_IN),
        .clear_in (timer_idle),
        .tick_out (tick)
    );

    eos_delay #(
        .DELAY_TICKS (`EOS_ARST_DELAY_MS)
    ) u_delay (
        .clk_in   (CORE_CLK_IN),
        .reset_in (RESET_IN),
        .arm_in   (arst_allowed),
        .tick_in  (tick),
        .idle_out (timer_idle),
        .done_out (arst_done)
    );

    // trip latches; a fault still present at the reset edge trips again
    always @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN)
        begin
            trip_crit  <= 1'b0;
            trip_other <= 1'b0;
            tries      <= 4'h0;
        end
        else
        begin
            if (crit_now)
                trip_crit <= 1'b1;
            else if (arst_done || clr_pulse)
                trip_crit <= 1'b0;
            if (other_now)
                trip_other <= 1'b1;
            else if (clr_pulse || entering)
                trip_other <= 1'b0;
            // attempt count restarts with each stay in override
            if (entering || leaving)
                tries <= 4'h0;
            else if (arst_done && tries != 4'hF)
                tries <= tries + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // drive commands
    // ----------------------------------------------------------------
    assign run_normal = GENERAL_ENABLE_IN && !STOP_CMD_IN;

    // operating state shown by the indicator
    always @*
    begin
        next_opst = `EOS_OPST_READY;
        if (next_active)
            next_opst = `EOS_OPST_FIRE;
        else if (trip_crit || trip_other)
            next_opst = `EOS_OPST_FAULT;
        else if (run_normal)
            next_opst = `EOS_OPST_RUN;
    end

    // all drive outputs registered
    always @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN)
        begin
            FIRE_MODE_ALARM_OUT <= 1'b0;
            OPERATING_STATE_OUT <= `EOS_OPST_READY;
            DIGITAL_OUTPUT_OUT  <= 1'b0;
            PULSE_ENABLE_OUT    <= 1'b0;
            SPEED_REF_OUT       <= 16'h0000;
            FAULT_TRIP_OUT      <= 1'b0;
            FAULT_RESET_OUT     <= 1'b0;
        end
        else
        begin
            FIRE_MODE_ALARM_OUT <= alarm;
            OPERATING_STATE_OUT <= next_opst;
            DIGITAL_OUTPUT_OUT  <= next_active && ctrl[`EOS_CTRL_DOUT_BIT];
            FAULT_TRIP_OUT      <= trip_crit || trip_other;
            FAULT_RESET_OUT     <= arst_done;
            if (next_active && cfg == `EOS_CFG_MAXSPD)
                SPEED_REF_OUT <= max_speed;
            else
                SPEED_REF_OUT <= SPEED_REF_IN;
            if (next_active && cfg == `EOS_CFG_COAST)
                PULSE_ENABLE_OUT <= 1'b0;
            else if (next_active)
                PULSE_ENABLE_OUT <= !trip_crit;
            else
                PULSE_ENABLE_OUT <= run_normal && !trip_crit && !trip_other;
        end
    end

    // ----------------------------------------------------------------
    // interrupt status
    // ----------------------------------------------------------------
    assign events[`EOS_IRQ_ENTER_BIT] = entering;
    assign events[`EOS_IRQ_EXIT_BIT]  = leaving;
    assign events[`EOS_IRQ_CRIT_BIT]  = crit_now && !trip_crit;
    assign events[`EOS_IRQ_SUPP_BIT]  = OTHER_FAULT_IN && active;
    assign events[`EOS_IRQ_ARST_BIT]  = arst_done;
    assign w1c = (wr_pend && wr_addr == `EOS_IRQ_STATUS_OFS) ?
                 HWDATA_IN[`EOS_IRQ_WIDTH-1:0] : 5'h00;

    // a new event in the clearing cycle keeps its bit set
    always @*
    begin
        next_irq_status = (irq_status & ~w1c) | events;
    end

    always @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN)
        begin
            irq_status <= 5'h00;
            IRQ_OUT    <= 1'b0;
        end
        else
        begin
            irq_status <= next_irq_status;
            IRQ_OUT    <= |(next_irq_status & irq_mask);
        end
    end

    // ----------------------------------------------------------------
    // ahb-lite slave
    // ----------------------------------------------------------------
    // zero wait states; any size is treated as a full word
    assign addr_phase = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
    assign addr_ofs   = {HADDR_IN[7:2], 2'b00};

    // read mux; unmapped offsets read as zero
    always @*
    begin
        rd_mux = 32'h0000_0000;
        case (addr_ofs)
            `EOS_CTRL_OFS:
                rd_mux[`EOS_CTRL_WIDTH-1:0] = ctrl;
            `EOS_STATUS_OFS:
            begin
                rd_mux[`EOS_STAT_ACTIVE_BIT] = active;
                rd_mux[`EOS_STAT_INPUT_BIT]  = FIRE_INPUT_N_IN;
                rd_mux[`EOS_STAT_SEEN_BIT]   = seen;
                rd_mux[`EOS_STAT_TRIP_BIT]   = trip_crit;
                rd_mux[`EOS_STAT_ALARM_BIT]  = alarm;
                rd_mux[`EOS_STAT_OPST_MSB:`EOS_STAT_OPST_LSB]   = OPERATING_STATE_OUT;
                rd_mux[`EOS_STAT_TRIES_MSB:`EOS_STAT_TRIES_LSB] = tries;
            end
            `EOS_IRQ_STATUS_OFS:
                rd_mux[`EOS_IRQ_WIDTH-1:0] = irq_status;
            `EOS_IRQ_MASK_OFS:
                rd_mux[`EOS_IRQ_WIDTH-1:0] = irq_mask;
            `EOS_ENTRY_LOG_OFS:
                rd_mux[15:0] = entry_count;
            `EOS_MAX_SPEED_OFS:
                rd_mux[15:0] = max_speed;
            default:
                rd_mux = 32'h0000_0000;
        endcase
    end

    // address phase capture and read data; a read right after a write
    // to the same offset sees the old value, traded for zero wait states
    always @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN)
        begin
            wr_pend       <= 1'b0;
            wr_addr       <= 8'h00;
            HRDATA_OUT    <= 32'h0000_0000;
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT     <= 1'b0;
        end
        else
        begin
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT     <= 1'b0;
            wr_pend       <= addr_phase && HWRITE_IN;
            if (addr_phase)
                wr_addr <= addr_ofs;
            if (addr_phase && !HWRITE_IN)
                HRDATA_OUT <= rd_mux;
        end
    end

    // data phase writes; the fault clear bit never stores
    always @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN)
        begin
            ctrl      <= `EOS_CTRL_RST;
            irq_mask  <= `EOS_IRQ_MASK_RST;
            max_speed <= `EOS_MAX_SPEED_RST;
        end
        else if (wr_pend)
        begin
            case (wr_addr)
                `EOS_CTRL_OFS:
                    ctrl <= HWDATA_IN[`EOS_CTRL_DOUT_BIT:0];
                `EOS_IRQ_MASK_OFS:
                    irq_mask <= HWDATA_IN[`EOS_IRQ_WIDTH-1:0];
                `EOS_MAX_SPEED_OFS:
                    max_speed <= HWDATA_IN[15:0];
                default:
                    ctrl <= ctrl;
            endcase
        end
    end

endmodule

// file: verilog/eos_tick.v
// millisecond enable pulse generator with restart
`timescale 1ns/100ps

module eos_tick
#(
    parameter TICK_CYC = 100000
)
(
    // clock and reset
    input  wire        clk_in,
    input  wire        reset_in,
    // control
    input  wire        clear_in,
    // enable pulse
    output reg         tick_out
);

    reg [31:0] count;

    // divider, restarted so a delay begins on a whole period
    always @(posedge clk_in)
    begin
        if (reset_in || clear_in)
        begin
            count    <= 32'h0000_0000;
            tick_out <= 1'b0;
        end
        else if (count == TICK_CYC - 1)
        begin
            count    <= 32'h0000_0000;
            tick_out <= 1'b1;
        end
        else
        begin
            count    <= count + 32'h0000_0001;
            tick_out <= 1'b0;
        end
    end

endmodule
